// ---- logic/prescaler_unit.sv ----
// Shared ripple-style prescaler with selectable division.
`timescale 1ns/1ps
`default_nettype none
module prescaler_unit
    import timer_wdt_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              rstn_i,
    input  wire logic              clear_i,
    input  wire logic              tick_i,
    input  wire logic [RATE_W-1:0] rate_i,
    input  wire logic              wdt_mode_i,
    output logic                   tick_o
);

    logic [7:0] cnt_reg;
    logic [7:0] mask;

    assign mask = rate_mask(rate_i, wdt_mode_i);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 8'h00;
        end else if (clear_i) begin
            cnt_reg <= 8'h00;
        end else if (tick_i) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // A zero mask passes every input tick straight through, except in a cycle with clear_i high.
    assign tick_o = tick_i & ~clear_i & ((cnt_reg & mask) == mask);

endmodule : prescaler_unit
`default_nettype wire

// ---- logic/timer_watchdog_prescaler.sv ----
// Eight-bit timer with a prescaler shared with the watchdog, and its register file.
//
// Notes on behaviour
// - Prescaler reassignable any time, no halt needed.
// - Timer write clears prescaler when timer owns it.
// - Option fields at bits 5,4,3,2:0; resets all ones.
// - Timer count read/write, survives non power-on resets.
// - Interrupt control at both addresses; cleared on reset.
// - Watchdog runs only when configuration enable set.
// - Watchdog counts its own oscillator, not core clock.
// - Watchdog time-out wakes the device from sleep.
// - Overflow flag set on overflow unless a soft or watchdog reset hits that cycle; software clears.
`timescale 1ns/1ps
`default_nettype none
module timer_watchdog_prescaler
    import timer_wdt_pkg::*;
(
    input  wire logic               core_clk_i,
    input  wire logic               rstn_i,
    input  wire logic               soft_rst_i,
    input  wire logic [ADDR_W-1:0]  addr_i,
    input  wire logic [DATA_W-1:0]  wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic      [DATA_W-1:0]  rdata_o,
    input  wire logic               timer_clk_pin_i,
    input  wire logic               wdt_osc_i,
    input  wire logic               watchdog_cfg_enable_i,
    input  wire logic               watchdog_clear_instr_i,
    input  wire logic               sleep_i,
    output logic                    irq_o,
    output logic                    wdt_reset_o,
    output logic                    wake_o,
    output logic      [PORTA_W-1:0] porta_direction_o
);

    logic [7:0]         timer_count_reg;
    logic [7:0]         irq_control_reg;
    logic [7:0]         option_config_reg;
    logic [PORTA_W-1:0] porta_direction_reg;
    logic [EVT_W-1:0]   event_status_reg;
    logic [EVT_W-1:0]   event_mask_reg;
    logic               cfg_enable_reg;
    logic               cfg_loaded_reg;
    logic               assign_prev_reg;

    // Pin synchronisers and qualified levels.
    logic pin_s1_reg;
    logic pin_s2_reg;
    logic pin_s3_reg;
    logic pin_level_reg;
    logic osc_s1_reg;
    logic osc_s2_reg;
    logic osc_s3_reg;
    logic osc_level_reg;

    logic                    wr_timer;
    logic                    wr_irq;
    logic                    wr_option;
    logic                    wr_porta;
    logic                    wr_status;
    logic                    wr_mask;
    logic                    local_rst;
    logic                    prescaler_to_wdt;
    logic [RATE_W-1:0]       rate;
    logic                    pin_rise;
    logic                    pin_fall;
    logic                    pin_tick;
    logic                    src_tick;
    logic                    wdt_base_tick;
    logic                    presc_in;
    logic                    presc_out;
    logic                    presc_clear;
    logic                    timer_inc;
    logic                    timer_ovf;
    logic                    wdt_tick;
    logic                    wdt_clear;
    logic                    wdt_timeout;
    logic                    wdt_reset_evt;
    logic                    irq_pending;
    logic [EVT_W-1:0]        events;
    logic [DATA_W-1:0]       rdata_next;

    // Address decode.
    always_comb begin
        wr_timer  = 1'b0;
        wr_irq    = 1'b0;
        wr_option = 1'b0;
        wr_porta  = 1'b0;
        wr_status = 1'b0;
        wr_mask   = 1'b0;
        if (!wr_i) begin
            wr_timer = 1'b0;
        end else if (addr_i == TIMER_COUNT_ADDR) begin
            wr_timer = 1'b1;
        end else if (addr_i == IRQ_CONTROL_ADDR || addr_i == IRQ_CONTROL_ALT_ADDR) begin
            wr_irq = 1'b1;
        end else if (addr_i == OPTION_CONFIG_ADDR) begin
            wr_option = 1'b1;
        end else if (addr_i == PORTA_DIR_ADDR) begin
            wr_porta = 1'b1;
        end else if (addr_i == EVENT_STATUS_ADDR) begin
            wr_status = 1'b1;
        end else if (addr_i == EVENT_MASK_ADDR) begin
            wr_mask = 1'b1;
        end
    end

    assign prescaler_to_wdt = option_config_reg[OPT_ASSIGN_BIT];
    assign rate             = option_config_reg[OPT_RATE_LSB +: RATE_W];

    // The configuration enable is a strap, caught once after reset release.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_enable_reg <= 1'b0;
            cfg_loaded_reg <= 1'b0;
        end else if (!cfg_loaded_reg) begin
            cfg_enable_reg <= watchdog_cfg_enable_i;
            cfg_loaded_reg <= 1'b1;
        end
    end

    // Pin synchroniser; a change counts once stages two and three agree.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1_reg    <= 1'b0;
            pin_s2_reg    <= 1'b0;
            pin_s3_reg    <= 1'b0;
            pin_level_reg <= 1'b0;
        end else begin
            pin_s1_reg <= timer_clk_pin_i;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            if (pin_s2_reg == pin_s3_reg) begin
                pin_level_reg <= pin_s3_reg;
            end
        end
    end

    // Watchdog oscillator synchroniser.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_s1_reg    <= 1'b0;
            osc_s2_reg    <= 1'b0;
            osc_s3_reg    <= 1'b0;
            osc_level_reg <= 1'b0;
        end else begin
            osc_s1_reg <= wdt_osc_i;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
            if (osc_s2_reg == osc_s3_reg) begin
                osc_level_reg <= osc_s3_reg;
            end
        end
    end

    assign pin_rise = (pin_s2_reg == pin_s3_reg) & pin_s3_reg & ~pin_level_reg;
    assign pin_fall = (pin_s2_reg == pin_s3_reg) & ~pin_s3_reg & pin_level_reg;
    assign pin_tick = option_config_reg[OPT_EDGE_SEL_BIT] ? pin_fall : pin_rise;

    // The internal source stops in sleep.
    assign src_tick = option_config_reg[OPT_CLK_SRC_BIT] ? pin_tick : ~sleep_i;

    // Watchdog base tick comes only from its own oscillator.
    assign wdt_base_tick = (osc_s2_reg == osc_s3_reg) & osc_s3_reg & ~osc_level_reg;

    // Prescaler routing follows the assignment bit.
    assign presc_in = prescaler_to_wdt ? wdt_base_tick : src_tick;
    assign timer_inc = prescaler_to_wdt ? src_tick : presc_out;
    assign wdt_tick  = prescaler_to_wdt ? presc_out : wdt_base_tick;
    assign wdt_clear = watchdog_clear_instr_i | soft_rst_i;

    // An awake time-out clears the prescaler a cycle late to avoid a loop.
    assign presc_clear = (wr_timer & ~prescaler_to_wdt)
                       | (watchdog_clear_instr_i & prescaler_to_wdt)
                       | (assign_prev_reg != prescaler_to_wdt)
                       | soft_rst_i | wdt_reset_o;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            assign_prev_reg <= OPTION_RESET[OPT_ASSIGN_BIT];
        end else begin
            assign_prev_reg <= prescaler_to_wdt;
        end
    end

    prescaler_unit u_prescaler (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .clear_i    (presc_clear),
        .tick_i     (presc_in),
        .rate_i     (rate),
        .wdt_mode_i (prescaler_to_wdt),
        .tick_o     (presc_out)
    );

    watchdog_counter u_watchdog (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .enable_i   (cfg_enable_reg),
        .clear_i    (wdt_clear),
        .tick_i     (wdt_tick),
        .timeout_o  (wdt_timeout)
    );

    // An awake time-out resets the device; an asleep one only wakes it.
    assign wdt_reset_evt = wdt_timeout & ~sleep_i;
    assign local_rst     = soft_rst_i | wdt_reset_evt;

    // A timer write wins over an increment.
    assign timer_ovf = timer_inc & ~wr_timer & (timer_count_reg == TIMER_MAX);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timer_count_reg <= TIMER_RESET;
        end else if (wr_timer) begin
            timer_count_reg <= wdata_i;
        end else if (timer_inc) begin
            timer_count_reg <= timer_count_reg + 8'h01;
        end
    end

    // Option returns to all ones on every reset.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            option_config_reg <= OPTION_RESET;
        end else if (local_rst) begin
            option_config_reg <= OPTION_RESET;
        end else if (wr_option) begin
            option_config_reg <= wdata_i;
        end
    end

    // The overflow flag sets regardless of enables and beats a clear.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_control_reg <= IRQ_CONTROL_RESET;
        end else if (local_rst) begin
            irq_control_reg <= IRQ_CONTROL_RESET;
        end else if (wr_irq) begin
            irq_control_reg                   <= wdata_i;
            irq_control_reg[IRQ_TMR_FLAG_BIT] <= wdata_i[IRQ_TMR_FLAG_BIT] | timer_ovf;
        end else if (timer_ovf) begin
            irq_control_reg[IRQ_TMR_FLAG_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            porta_direction_reg <= PORTA_DIR_RESET;
        end else if (local_rst) begin
            porta_direction_reg <= PORTA_DIR_RESET;
        end else if (wr_porta) begin
            porta_direction_reg <= wdata_i[PORTA_W-1:0];
        end
    end

    // Sticky event status, write one to clear; an event beats the clear.
    always_comb begin
        events                  = EVT_RESET;
        events[EVT_TMR_OVF_BIT] = timer_ovf;
        events[EVT_WDT_TO_BIT]  = wdt_timeout;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            event_status_reg <= EVT_RESET;
        end else if (wr_status) begin
            event_status_reg <= (event_status_reg & ~wdata_i[EVT_W-1:0]) | events;
        end else begin
            event_status_reg <= event_status_reg | events;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            event_mask_reg <= EVT_RESET;
        end else if (wr_mask) begin
            event_mask_reg <= wdata_i[EVT_W-1:0];
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_comb begin
        rdata_next = 8'h00;
        if (!rd_i) begin
            rdata_next = 8'h00;
        end else if (addr_i == TIMER_COUNT_ADDR) begin
            rdata_next = timer_count_reg;
        end else if (addr_i == IRQ_CONTROL_ADDR || addr_i == IRQ_CONTROL_ALT_ADDR) begin
            rdata_next = irq_control_reg;
        end else if (addr_i == OPTION_CONFIG_ADDR) begin
            rdata_next = option_config_reg;
        end else if (addr_i == PORTA_DIR_ADDR) begin
            rdata_next = {2'b00, porta_direction_reg};
        end else if (addr_i == EVENT_STATUS_ADDR) begin
            rdata_next = {6'h00, event_status_reg};
        end else if (addr_i == EVENT_MASK_ADDR) begin
            rdata_next = {6'h00, event_mask_reg};
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rdata_next;
        end
    end

    // Timer interrupt condition that may end sleep.
    assign irq_pending = irq_control_reg[IRQ_TMR_EN_BIT] & irq_control_reg[IRQ_TMR_FLAG_BIT];

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_o       <= 1'b0;
            wdt_reset_o <= 1'b0;
            wake_o      <= 1'b0;
        end else begin
            irq_o       <= |((event_status_reg | events) & event_mask_reg);
            wdt_reset_o <= wdt_reset_evt;
            wake_o      <= sleep_i & (wdt_timeout | irq_pending);
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            porta_direction_o <= PORTA_DIR_RESET;
        end else begin
            porta_direction_o <= (wr_porta && !local_rst) ? wdata_i[PORTA_W-1:0]
                               : (local_rst ? PORTA_DIR_RESET : porta_direction_reg);
        end
    end

endmodule : timer_watchdog_prescaler
`default_nettype wire

// ---- logic/watchdog_counter.sv ----
// Watchdog counter that times out after a fixed number of ticks.
`timescale 1ns/1ps
`default_nettype none
module watchdog_counter
    import timer_wdt_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    input  wire logic enable_i,
    input  wire logic clear_i,
    input  wire logic tick_i,
    output logic      timeout_o
);

    logic [7:0] cnt_reg;
    logic       at_end;

    assign at_end = (cnt_reg == WDT_TERMINAL);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 8'h00;
        end else if (!enable_i || clear_i) begin
            cnt_reg <= 8'h00;
        end else if (tick_i) begin
            cnt_reg <= at_end ? 8'h00 : (cnt_reg + 8'h01);
        end
    end

    assign timeout_o = enable_i & ~clear_i & tick_i & at_end;

endmodule : watchdog_counter
`default_nettype wire

// ---- shared/timer_wdt_pkg.sv ----
// Shared constants for the timer and watchdog block.
`default_nettype none
package timer_wdt_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register byte addresses.
    localparam logic [7:0] TIMER_COUNT_ADDR     = 8'h01;
    localparam logic [7:0] IRQ_CONTROL_ADDR     = 8'h0B;
    localparam logic [7:0] IRQ_CONTROL_ALT_ADDR = 8'h8B;
    localparam logic [7:0] OPTION_CONFIG_ADDR   = 8'h81;
    localparam logic [7:0] PORTA_DIR_ADDR       = 8'h85;
    localparam logic [7:0] EVENT_STATUS_ADDR    = 8'h90;
    localparam logic [7:0] EVENT_MASK_ADDR      = 8'h91;

    // Option register fields.
    localparam int OPT_CLK_SRC_BIT  = 5;
    localparam int OPT_EDGE_SEL_BIT = 4;
    localparam int OPT_ASSIGN_BIT   = 3;
    localparam int OPT_RATE_LSB     = 0;
    localparam int RATE_W           = 3;

    // Interrupt control fields.
    localparam int IRQ_GLOBAL_EN_BIT = 7;
    localparam int IRQ_TMR_EN_BIT    = 5;
    localparam int IRQ_TMR_FLAG_BIT  = 2;

    // Event status and mask fields.
    localparam int EVT_TMR_OVF_BIT = 0;
    localparam int EVT_WDT_TO_BIT  = 1;
    localparam int EVT_W           = 2;

    // Port A direction width.
    localparam int PORTA_W = 6;

    // Reset values.
    localparam logic [7:0]         OPTION_RESET      = 8'hFF;
    localparam logic [7:0]         IRQ_CONTROL_RESET = 8'h00;
    localparam logic [7:0]         TIMER_RESET       = 8'h00;
    localparam logic [PORTA_W-1:0] PORTA_DIR_RESET   = 6'h3F;
    localparam logic [EVT_W-1:0]   EVT_RESET         = 2'h0;

    // Watchdog terminal count in watchdog ticks.
    localparam logic [7:0] WDT_TERMINAL = 8'hFF;
    localparam logic [7:0] TIMER_MAX    = 8'hFF;

    // Mask of prescaler bits that must be all ones for an output tick.
    function automatic logic [7:0] rate_mask(input logic [RATE_W-1:0] rate, input logic wdt_mode);
        logic [3:0] n;
        n = wdt_mode ? {1'b0, rate} : ({1'b0, rate} + 4'h1);
        rate_mask = ~(8'hFF << n);
    endfunction : rate_mask

endpackage : timer_wdt_pkg
`default_nettype wire

// ---- tb/timer_watchdog_prescaler_chk.sv ----
// Port-level assertions for the timer block.
`timescale 1ns/1ps
`default_nettype none
module timer_watchdog_prescaler_chk
    import timer_wdt_pkg::*;
(
    input wire logic               core_clk_i,
    input wire logic               rstn_i,
    input wire logic               soft_rst_i,
    input wire logic [ADDR_W-1:0]  addr_i,
    input wire logic [DATA_W-1:0]  wdata_i,
    input wire logic               wr_i,
    input wire logic               rd_i,
    input wire logic [DATA_W-1:0]  rdata_o,
    input wire logic               timer_clk_pin_i,
    input wire logic               wdt_osc_i,
    input wire logic               watchdog_cfg_enable_i,
    input wire logic               watchdog_clear_instr_i,
    input wire logic               sleep_i,
    input wire logic               irq_o,
    input wire logic               wdt_reset_o,
    input wire logic               wake_o,
    input wire logic [PORTA_W-1:0] porta_direction_o
);
    logic first_q;
    logic strap_q;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    // Mirrors the one-time strap capture.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            first_q <= 1'b1;
            strap_q <= 1'b0;
        end else begin
            first_q <= 1'b0;
            if (first_q) begin
                strap_q <= watchdog_cfg_enable_i;
            end
        end
    end

    chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not idle");
    chk_timer_readback: assert property ((wr_i && addr_i == TIMER_COUNT_ADDR) ##1
        (rd_i && addr_i == TIMER_COUNT_ADDR) |=> (8'(rdata_o - $past(wdata_i, 2)) <= 8'h01))
        else $error("timer count lost a write");
    chk_opt_soft_reset: assert property (soft_rst_i ##1 (rd_i && addr_i == OPTION_CONFIG_ADDR)
        |=> rdata_o == OPTION_RESET) else $error("option not reset");
    chk_irqc_soft_reset: assert property (soft_rst_i ##1 (rd_i && addr_i == IRQ_CONTROL_ALT_ADDR)
        |=> !rdata_o[IRQ_GLOBAL_EN_BIT] && !rdata_o[IRQ_TMR_EN_BIT]) else $error("enables not cleared");
    chk_opt_after_wdt: assert property (wdt_reset_o && rd_i && addr_i == OPTION_CONFIG_ADDR
        |=> rdata_o == OPTION_RESET) else $error("option not reset by watchdog");
    chk_wdt_one_pulse: assert property (wdt_reset_o |=> !wdt_reset_o)
        else $error("watchdog reset too long");
    chk_wdt_awake_only: assert property (wdt_reset_o |-> !$past(sleep_i))
        else $error("watchdog reset while asleep");
    chk_wake_asleep: assert property ($rose(wake_o) |-> $past(sleep_i))
        else $error("wake while awake");
    chk_strap_gates_wdt: assert property (!first_q && !strap_q |-> !wdt_reset_o)
        else $error("watchdog fired while off");
    chk_status_sticky: assert property ((rd_i && addr_i == EVENT_STATUS_ADDR) [*2]
        |=> (rdata_o & $past(rdata_o)) == $past(rdata_o)) else $error("status bit dropped");
endmodule : timer_watchdog_prescaler_chk

bind timer_watchdog_prescaler timer_watchdog_prescaler_chk chk (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .soft_rst_i(soft_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_clk_pin_i(timer_clk_pin_i),
    .wdt_osc_i(wdt_osc_i), .watchdog_cfg_enable_i(watchdog_cfg_enable_i),
    .watchdog_clear_instr_i(watchdog_clear_instr_i), .sleep_i(sleep_i), .irq_o(irq_o),
    .wdt_reset_o(wdt_reset_o), .wake_o(wake_o), .porta_direction_o(porta_direction_o));
`default_nettype wire

// ---- tb/timer_watchdog_prescaler_tb.sv ----
// Self-checking bench for the timer block.
`timescale 1ns/1ps
`default_nettype none
module timer_watchdog_prescaler_tb
    import timer_wdt_pkg::*;
    ;
    logic core_clk_i = 1'b0, rstn_i = 1'b0, soft_rst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic timer_clk_pin_i = 1'b0, wdt_osc_i = 1'b0, watchdog_cfg_enable_i = 1'b1;
    logic watchdog_clear_instr_i = 1'b0, sleep_i = 1'b0, irq_o, wdt_reset_o, wake_o;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, d, outs_q;
    logic [PORTA_W-1:0] porta_direction_o;
    logic osc_run = 1'b0, seen_wake = 1'b0;
    int osc_cnt = 0, n_wdt = 0, num_errors = 0, n_tests = 0, i, w, n;
    integer seed = 32'h17A1;

    timer_watchdog_prescaler dut (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .soft_rst_i(soft_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_clk_pin_i(timer_clk_pin_i),
        .wdt_osc_i(wdt_osc_i), .watchdog_cfg_enable_i(watchdog_cfg_enable_i),
        .watchdog_clear_instr_i(watchdog_clear_instr_i), .sleep_i(sleep_i), .irq_o(irq_o),
        .wdt_reset_o(wdt_reset_o), .wake_o(wake_o), .porta_direction_o(porta_direction_o));

    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end

    // Watchdog oscillator, ten core cycles a period.
    always @(posedge core_clk_i) begin
        if (osc_run) begin
            osc_cnt <= (osc_cnt == 4) ? 0 : osc_cnt + 1;
            if (osc_cnt == 4)
                wdt_osc_i <= ~wdt_osc_i;
        end
    end

    // Outputs are sampled mid-cycle.
    always @(negedge core_clk_i) begin
        outs_q = {irq_o, wake_o, porta_direction_o};
        if (wdt_reset_o === 1'b1)
            n_wdt++;
        if (wake_o === 1'b1)
            seen_wake = 1'b1;
    end

    function automatic logic [7:0] exp_div(input int cycles, input int rate);
        return 8'(cycles >> (rate + 1));
    endfunction : exp_div

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic bus(input logic w_s, input logic r_s, input logic [7:0] a, input logic [7:0] v);
        wr_i <= w_s;
        rd_i <= r_s;
        addr_i <= a;
        wdata_i <= v;
        @(posedge core_clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bus(1'b1, 1'b0, a, v);
    endtask : wr

    task automatic tick(input int cnt);
        {wr_i, rd_i} <= 2'b00;
        repeat (cnt) @(posedge core_clk_i);
    endtask : tick

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        bus(1'b0, 1'b1, a, 8'h00);
        {wr_i, rd_i} <= 2'b00;
        @(negedge core_clk_i);
        v = rdata_o;
        @(posedge core_clk_i);
    endtask : rd

    task automatic clr();
        {wr_i, rd_i} <= 2'b00;
        watchdog_clear_instr_i <= 1'b1;
        @(posedge core_clk_i);
        watchdog_clear_instr_i <= 1'b0;
    endtask : clr

    task automatic pulse(input int cnt);
        repeat (cnt) begin
            timer_clk_pin_i <= 1'b1;
            tick(6);
            timer_clk_pin_i <= 1'b0;
            tick(6);
        end
    endtask : pulse

    task automatic por(input logic strap);
        rstn_i <= 1'b0;
        watchdog_cfg_enable_i <= strap;
        repeat (3) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
    endtask : por

    task automatic finish_test();
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    initial begin
        #2400000;
        num_errors++;
        finish_test();
    end

    initial begin
        por(1'b1);
        rd(OPTION_CONFIG_ADDR, d);
        check(d, OPTION_RESET);
        rd(IRQ_CONTROL_ADDR, d);
        check(d, IRQ_CONTROL_RESET);
        rd(TIMER_COUNT_ADDR, d);
        check(d, 8'h00);
        rd(PORTA_DIR_ADDR, d);
        check(d, 8'h3F);
        rd(8'h40, d);
        check(d, 8'h00);
        $display("test reset_values done");
        for (i = 0; i < 4; i++) begin
            w = $random(seed);
            wr(OPTION_CONFIG_ADDR, 8'(w) | 8'h20);
            wr(TIMER_COUNT_ADDR, 8'(w >> 8));
            rd(TIMER_COUNT_ADDR, d);
            check(d, 8'(w >> 8));
            rd(OPTION_CONFIG_ADDR, d);
            check(d, 8'(w) | 8'h20);
            wr(IRQ_CONTROL_ADDR, 8'(w >> 16));
            rd(IRQ_CONTROL_ALT_ADDR, d);
            check(d, 8'(w >> 16));
            wr(PORTA_DIR_ADDR, 8'(w >> 24));
            rd(PORTA_DIR_ADDR, d);
            check(d, 8'(w >> 24) & 8'h3F);
            check({2'b00, outs_q[5:0]}, 8'(w >> 24) & 8'h3F);
        end
        $display("test register_access done");
        for (i = 0; i < 8; i++) begin
            n = 3 * (2 << i) + (1 << i) - 1;
            wr(OPTION_CONFIG_ADDR, 8'(i));
            wr(TIMER_COUNT_ADDR, 8'h00);
            tick(n);
            rd(TIMER_COUNT_ADDR, d);
            check(d, exp_div(n, i));
        end
        for (i = 0; i < 4; i++) begin
            w = $random(seed);
            n = 1 + ((w >> 8) & 31);
            wr(OPTION_CONFIG_ADDR, 8'h08 | (8'(w) & 8'h07));
            wr(TIMER_COUNT_ADDR, 8'(w >> 16));
            tick(n);
            rd(TIMER_COUNT_ADDR, d);
            check(d, 8'(w >> 16) + 8'(n));
        end
        $display("test prescaler done");
        wr(EVENT_MASK_ADDR, 8'h01);
        wr(IRQ_CONTROL_ADDR, 8'h00);
        wr(OPTION_CONFIG_ADDR, 8'h08);
        wr(TIMER_COUNT_ADDR, 8'hFD);
        tick(8);
        rd(IRQ_CONTROL_ADDR, d);
        check(d, 8'h04);
        rd(EVENT_STATUS_ADDR, d);
        check(d & 8'h01, 8'h01);
        check(outs_q & 8'h80, 8'h80);
        bus(1'b0, 1'b1, EVENT_STATUS_ADDR, 8'h00);
        bus(1'b0, 1'b1, EVENT_STATUS_ADDR, 8'h00);
        wr(EVENT_STATUS_ADDR, 8'h01);
        wr(EVENT_MASK_ADDR, 8'h00);
        tick(300);
        check(outs_q & 8'h80, 8'h00);
        rd(EVENT_STATUS_ADDR, d);
        check(d & 8'h01, 8'h01);
        wr(EVENT_MASK_ADDR, 8'h01);
        tick(3);
        check(outs_q & 8'h80, 8'h80);
        wr(EVENT_STATUS_ADDR, 8'h01);
        tick(3);
        check(outs_q & 8'h80, 8'h00);
        $display("test overflow_irq done");
        clr();
        wr(OPTION_CONFIG_ADDR, 8'h20);
        wr(TIMER_COUNT_ADDR, 8'h5A);
        osc_run <= 1'b1;
        n_wdt = 0;
        repeat (6) begin
            tick(400);
            clr();
        end
        check(8'(n_wdt), 8'h00);
        for (i = 0; i < 3000 && n_wdt == 0; i++)
            bus(1'b0, 1'b1, OPTION_CONFIG_ADDR, 8'h00);
        tick(2);
        check(8'(n_wdt), 8'h01);
        check(8'(i > 2400 && i < 2700), 8'h01);
        rd(OPTION_CONFIG_ADDR, d);
        check(d, OPTION_RESET);
        rd(EVENT_STATUS_ADDR, d);
        check(d & 8'h02, 8'h02);
        rd(TIMER_COUNT_ADDR, d);
        check(d, 8'h5A);
        wr(TIMER_COUNT_ADDR, 8'h00);
        clr();
        wr(OPTION_CONFIG_ADDR, 8'h28);
        sleep_i <= 1'b1;
        seen_wake = 1'b0;
        for (i = 0; i < 3000 && !seen_wake; i++)
            tick(1);
        sleep_i <= 1'b0;
        clr();
        check(8'(seen_wake), 8'h01);
        check(8'(n_wdt), 8'h01);
        $display("test watchdog done");
        wr(TIMER_COUNT_ADDR, 8'hC3);
        pulse(3);
        rd(TIMER_COUNT_ADDR, d);
        check(d, 8'hC6);
        wr(OPTION_CONFIG_ADDR, 8'h38);
        timer_clk_pin_i <= 1'b1;
        tick(6);
        rd(TIMER_COUNT_ADDR, d);
        check(d, 8'hC6);
        timer_clk_pin_i <= 1'b0;
        tick(6);
        rd(TIMER_COUNT_ADDR, d);
        check(d, 8'hC7);
        for (i = 0; i < 2; i++) begin
            wr(i ? IRQ_CONTROL_ADDR : OPTION_CONFIG_ADDR, 8'hA0);
            tick(1);
            soft_rst_i <= 1'b1;
            @(posedge core_clk_i);
            soft_rst_i <= 1'b0;
            rd(i ? IRQ_CONTROL_ALT_ADDR : OPTION_CONFIG_ADDR, d);
            check(d, i ? IRQ_CONTROL_RESET : OPTION_RESET);
        end
        rd(TIMER_COUNT_ADDR, d);
        check(d, 8'hC7);
        $display("test pin_and_soft_reset done");
        por(1'b0);
        rd(TIMER_COUNT_ADDR, d);
        check(d, 8'h00);
        wr(OPTION_CONFIG_ADDR, 8'h00);
        n_wdt = 0;
        tick(3000);
        check(8'(n_wdt), 8'h00);
        $display("test strap_off done");
        finish_test();
    end
endmodule : timer_watchdog_prescaler_tb
`default_nettype wire
